//--- inc/ea_pkg.sv
// Package: constants, types and encodings for the effective-address generator
package ea_pkg;

	localparam int REG_W      = 32;
	localparam int ADDR_W     = 24;
	localparam int OFF_W      = 4;
	localparam int DATA_W     = 16;
	localparam int SEL_W      = 4;

	// Register port offsets (index; byte address not used, plain port)
	localparam logic [OFF_W-1:0] OFF_MODE    = 4'h0;
	localparam logic [OFF_W-1:0] OFF_SEL     = 4'h1;
	localparam logic [OFF_W-1:0] OFF_EXT0    = 4'h2;
	localparam logic [OFF_W-1:0] OFF_EXT1    = 4'h3;
	localparam logic [OFF_W-1:0] OFF_GO      = 4'h4;
	localparam logic [OFF_W-1:0] OFF_EA_LO   = 4'h5;
	localparam logic [OFF_W-1:0] OFF_EA_HI   = 4'h6;
	localparam logic [OFF_W-1:0] OFF_STATUS  = 4'h7;
	localparam logic [OFF_W-1:0] OFF_SW      = 4'h8;
	localparam logic [OFF_W-1:0] OFF_PC_LO   = 4'h9;
	localparam logic [OFF_W-1:0] OFF_PC_HI   = 4'hA;
	localparam logic [OFF_W-1:0] OFF_WR_LO   = 4'hB;
	localparam logic [OFF_W-1:0] OFF_WR_HI   = 4'hC;
	localparam logic [OFF_W-1:0] OFF_WR_SEL  = 4'hD;
	localparam logic [OFF_W-1:0] OFF_OPND_LO = 4'hE;
	localparam logic [OFF_W-1:0] OFF_OPND_HI = 4'hF;

	// Status word fields
	localparam int SW_C   = 0;
	localparam int SW_V   = 1;
	localparam int SW_Z   = 2;
	localparam int SW_N   = 3;
	localparam int SW_X   = 4;
	localparam int SW_IML = 8;
	localparam int SW_T   = 15;
	localparam int SW_S   = 13;
	localparam logic [15:0] SW_MASK  = 16'hA71F;
	localparam logic [15:0] SW_RESET = 16'h2700;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;

	// Step sizes
	localparam logic [2:0] STEP_BYTE = 3'h1;
	localparam logic [2:0] STEP_WORD = 3'h2;
	localparam logic [2:0] STEP_LONG = 3'h4;

	// General register select: 0..7 data, 8..14 address, 15 stack pointer
	localparam logic [SEL_W-1:0] SEL_STACK = 4'hF;

	typedef enum logic [3:0] {
		M_DATA_DIRECT, M_ADDR_DIRECT, M_ABS_SHORT, M_ABS_LONG,
		M_PC_DISP, M_PC_INDEX, M_INDIRECT, M_POSTINC, M_PREDEC,
		M_DISP, M_INDEX, M_IMMEDIATE, M_QUICK, M_IMPLIED
	} mode_t;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t_t;

	typedef enum logic [1:0] {IMP_SW, IMP_USP, IMP_SP, IMP_PC} implied_t;

	// Mode/select control word written by software
	typedef struct packed {
		mode_t      mode;
		size_t_t    size;
		implied_t   implied;
		logic [2:0] quick;
		logic       long_index;
	} ctrl_t;

	typedef struct packed {
		logic [SEL_W-1:0] base;
		logic [SEL_W-1:0] index;
	} sel_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              req;
		logic              write;
	} bus_req_t;

endpackage

//--- src/effective_address_generator.sv
// Programmer register set and effective-address generation with at most one bus access
// Summary of operation
// - Data-register-direct mode returns the selected data register; no bus access.
// - Address-register-direct mode returns the selected address register; no bus access.
// - Absolute short takes one extension word, absolute long takes two.
// - PC-relative with offset: address is PC plus 16-bit displacement.
// - PC-relative with index: PC plus index register plus 8-bit displacement.
// - Register-indirect: address is the address register contents unchanged.
// - Postincrement: use register as address, then add step size.
// - Predecrement: subtract step first, then use new value as address.
// - Indirect with offset: address register plus 16-bit displacement.
// - Indexed indirect: address register plus any index register plus 8-bit displacement.
// - Step is 1 for byte, 2 for word, 4 for long word.
// - Byte step on the stack pointer is 2 to keep word alignment.
// - Immediate data come from extension words; quick data from the instruction field.
// - Implied mode selects status word, user stack, active stack or PC.
// - Drive a 24-bit byte address, 16,777,216 locations.
// - Eight 32-bit data registers, written as byte, word or long.
// - Seven address registers and two stack pointers, word or long writes.
// - Any of the sixteen selectable general registers can serve as index; the inactive stack pointer cannot.
// - Hold a 32-bit program counter and 16-bit status word.
// - Status word holds 3-bit mask, five flags, trace and supervisor bits.
// - Bus access lasts until the responder acknowledges, fast or slow.
// - Address register seven is the active system stack pointer.
`timescale 1ns/1ps

module effective_address_generator #(
	parameter int NUM_DATA = 8,
	parameter int NUM_ADDR = 7
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic [ea_pkg::OFF_W-1:0]   reg_addr,
	input  wire logic [ea_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [ea_pkg::DATA_W-1:0]  reg_rdata,
	output ea_pkg::bus_req_t                bus_out,
	input  wire logic                       bus_ack,
	output logic      [ea_pkg::REG_W-1:0]   operand,
	output logic                            done
);

	localparam int REG_W = ea_pkg::REG_W;
	localparam int ADDR_W = ea_pkg::ADDR_W;

	typedef enum logic [1:0] {S_IDLE, S_BUS, S_FINISH} state_t;

	state_t            state;
	ea_pkg::ctrl_t     ctrl;
	ea_pkg::sel_t      sel;
	logic [15:0]       ext0;
	logic [15:0]       ext1;
	logic [15:0]       status_word;
	logic [REG_W-1:0]  pc;
	logic [REG_W-1:0]  data_bank [NUM_DATA];
	logic [REG_W-1:0]  addr_bank [NUM_ADDR];
	logic [REG_W-1:0]  user_stack_pointer;
	logic [REG_W-1:0]  super_stack_pointer;
	logic [REG_W-1:0]  effective_address;
	logic [REG_W-1:0]  wr_value;
	logic [3:0]        wr_sel;
	logic              ack_s1;
	logic              ack_s2;
	logic              bus_err_busy;

	// Active stack pointer follows the supervisor bit
	logic              super_mode;
	logic [REG_W-1:0]  sys_stack_ptr;
	assign super_mode    = status_word[ea_pkg::SW_S];
	assign sys_stack_ptr = super_mode ? super_stack_pointer : user_stack_pointer;

	// General register read, any of the sixteen selects (active stack pointer only)
	function automatic logic [REG_W-1:0] read_gen(input logic [3:0] s);
		logic [REG_W-1:0] r;
		r = '0;
		if (s < 4'(NUM_DATA))
			r = data_bank[s[2:0]];
		else if (s == ea_pkg::SEL_STACK)
			r = sys_stack_ptr;
		else
			r = addr_bank[3'(s - 4'(NUM_DATA))];
		return r;
	endfunction

	logic [REG_W-1:0]  base_val;
	logic [REG_W-1:0]  index_raw;
	logic [REG_W-1:0]  index_val;
	logic [REG_W-1:0]  disp_short;
	logic [REG_W-1:0]  disp_wide;
	logic [2:0]        step;
	logic              base_is_addr;
	logic [REG_W-1:0]  next_ea;
	logic [REG_W-1:0]  next_operand;
	logic              next_needs_bus;

	// A process, not an assign, so register updates also re-evaluate the reads
	always_comb begin
		base_val  = read_gen(sel.base);
		index_raw = read_gen(sel.index);
	end
	// Index may be word sign-extended or full long
	assign index_val = ctrl.long_index ? index_raw : {{16{index_raw[15]}}, index_raw[15:0]};
	assign disp_short = {{24{ext0[7]}}, ext0[7:0]};
	assign disp_wide  = {{16{ext0[15]}}, ext0};
	assign base_is_addr = sel.base >= 4'(NUM_DATA);

	// Step size per operand size; byte on stack pointer keeps word alignment
	always_comb begin
		case (ctrl.size)
			ea_pkg::SZ_BYTE: step = (sel.base == ea_pkg::SEL_STACK) ?
				ea_pkg::STEP_WORD : ea_pkg::STEP_BYTE;
			ea_pkg::SZ_WORD: step = ea_pkg::STEP_WORD;
			default:         step = ea_pkg::STEP_LONG;
		endcase
	end

	always_comb begin
		next_ea        = '0;
		next_operand   = '0;
		next_needs_bus = 1'b1;
		case (ctrl.mode)
			ea_pkg::M_DATA_DIRECT: begin
				next_operand   = data_bank[sel.base[2:0]];
				next_needs_bus = 1'b0;
			end
			ea_pkg::M_ADDR_DIRECT: begin
				next_operand   = base_val;
				next_needs_bus = 1'b0;
			end
			ea_pkg::M_ABS_SHORT: next_ea = disp_wide;
			ea_pkg::M_ABS_LONG:  next_ea = {ext1, ext0};
			ea_pkg::M_PC_DISP:   next_ea = pc + disp_wide;
			ea_pkg::M_PC_INDEX:  next_ea = pc + index_val + disp_short;
			ea_pkg::M_INDIRECT:  next_ea = base_val;
			ea_pkg::M_POSTINC:   next_ea = base_val;
			ea_pkg::M_PREDEC:    next_ea = base_val - REG_W'(step);
			ea_pkg::M_DISP:      next_ea = base_val + disp_wide;
			ea_pkg::M_INDEX:     next_ea = base_val + index_val + disp_short;
			ea_pkg::M_IMMEDIATE: begin
				next_needs_bus = 1'b0;
				next_operand   = (ctrl.size == ea_pkg::SZ_LONG) ? {ext1, ext0} :
					{16'h0000, ext0};
			end
			ea_pkg::M_QUICK: begin
				next_needs_bus = 1'b0;
				// Zero in the field stands for eight
				next_operand = (ctrl.quick == 3'h0) ? 32'h0000_0008 :
					{29'h0, ctrl.quick};
			end
			ea_pkg::M_IMPLIED: begin
				next_needs_bus = 1'b0;
				case (ctrl.implied)
					ea_pkg::IMP_SW:  next_operand = {16'h0000, status_word};
					ea_pkg::IMP_USP: next_operand = user_stack_pointer;
					ea_pkg::IMP_SP:  next_operand = sys_stack_ptr;
					default:         next_operand = pc;
				endcase
			end
			default: next_needs_bus = 1'b0;
		endcase
	end

	// Acknowledge comes from outside the clock domain
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= bus_ack;
			ack_s2 <= ack_s1;
		end
	end

	logic go;
	assign go = reg_wr && reg_addr == ea_pkg::OFF_GO && state == S_IDLE;

	// Access sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state             <= S_IDLE;
			effective_address <= '0;
			operand           <= '0;
			done              <= 1'b0;
			bus_out           <= '0;
		end else begin
			done <= 1'b0;
			case (state)
				S_IDLE: if (go) begin
					effective_address <= next_ea;
					if (next_needs_bus) begin
						bus_out.addr  <= next_ea[ADDR_W-1:0];
						bus_out.req   <= 1'b1;
						bus_out.write <= reg_wdata[0];
						state         <= S_BUS;
					end else begin
						operand <= next_operand;
						state   <= S_FINISH;
					end
				end
				S_BUS: if (ack_s2) begin
					// Access stretches until the responder answers
					bus_out.req <= 1'b0;
					operand     <= effective_address;
					state       <= S_FINISH;
				end
				// Wait for the acknowledge to fall so a stale one cannot end the next access
				S_FINISH: if (!ack_s2) begin
					done  <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Register file writes: software loads and address-mode write-back
	logic wr_lo;
	logic wr_hi;
	logic wr_do;
	assign wr_lo = reg_wr && reg_addr == ea_pkg::OFF_WR_LO;
	assign wr_hi = reg_wr && reg_addr == ea_pkg::OFF_WR_HI;
	assign wr_do = reg_wr && reg_addr == ea_pkg::OFF_WR_SEL;
	// Select travels with the strobe itself, so the write lands in the named register
	assign wr_sel = reg_wdata[3:0];

	// Write-back happens only on the go cycle, so at most once per access
	logic              wb_en;
	logic [REG_W-1:0]  wb_val;
	assign wb_en  = go && base_is_addr &&
		(ctrl.mode == ea_pkg::M_POSTINC || ctrl.mode == ea_pkg::M_PREDEC);
	assign wb_val = (ctrl.mode == ea_pkg::M_POSTINC) ?
		base_val + REG_W'(step) : next_ea;

	// Size-aware write of a general register
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
			input logic [REG_W-1:0] val, input logic [1:0] sz, input logic is_addr);
		logic [REG_W-1:0] r;
		r = val;
		if (is_addr) begin
			if (sz != 2'(ea_pkg::SZ_LONG))
				r = {{16{val[15]}}, val[15:0]};
		end else if (sz == 2'(ea_pkg::SZ_BYTE))
			r = {old[31:8], val[7:0]};
		else if (sz == 2'(ea_pkg::SZ_WORD))
			r = {old[31:16], val[15:0]};
		return r;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DATA; gi++) begin : g_data
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					data_bank[gi] <= '0;
				else if (wr_do && wr_sel == 4'(gi))
					data_bank[gi] <= merge(data_bank[gi], wr_value, ctrl.size, 1'b0);
			end
		end
		for (gi = 0; gi < NUM_ADDR; gi++) begin : g_addr
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					addr_bank[gi] <= '0;
				else if (wb_en && sel.base == 4'(gi + NUM_DATA))
					addr_bank[gi] <= wb_val;
				else if (wr_do && wr_sel == 4'(gi + NUM_DATA))
					addr_bank[gi] <= merge(addr_bank[gi], wr_value, ctrl.size, 1'b1);
			end
		end
	endgenerate

	// Two stack pointers; the active one is chosen by the supervisor bit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			user_stack_pointer  <= '0;
			super_stack_pointer <= '0;
		end else if (wb_en && sel.base == ea_pkg::SEL_STACK) begin
			if (super_mode)
				super_stack_pointer <= wb_val;
			else
				user_stack_pointer <= wb_val;
		end else if (wr_do && wr_sel == ea_pkg::SEL_STACK) begin
			if (super_mode)
				super_stack_pointer <= merge(super_stack_pointer, wr_value, ctrl.size, 1'b1);
			else
				user_stack_pointer <= merge(user_stack_pointer, wr_value, ctrl.size, 1'b1);
		end
	end

	// Control, extension words, program counter and status word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl        <= '0;
			sel         <= '0;
			ext0        <= '0;
			ext1        <= '0;
			wr_value    <= '0;
			pc          <= ea_pkg::PC_RESET;
			status_word <= ea_pkg::SW_RESET;
		end else if (reg_wr && state == S_IDLE) begin
			case (reg_addr)
				ea_pkg::OFF_MODE:  ctrl <= ea_pkg::ctrl_t'(reg_wdata[$bits(ea_pkg::ctrl_t)-1:0]);
				ea_pkg::OFF_SEL:   sel  <= ea_pkg::sel_t'(reg_wdata[7:0]);
				ea_pkg::OFF_EXT0:  ext0 <= reg_wdata;
				ea_pkg::OFF_EXT1:  ext1 <= reg_wdata;
				// Unused status bits read as zero
				ea_pkg::OFF_SW:    status_word <= reg_wdata & ea_pkg::SW_MASK;
				ea_pkg::OFF_PC_LO: pc[15:0]  <= reg_wdata;
				ea_pkg::OFF_PC_HI: pc[31:16] <= reg_wdata;
				ea_pkg::OFF_WR_LO: wr_value[15:0]  <= reg_wdata;
				ea_pkg::OFF_WR_HI: wr_value[31:16] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read port: data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd) begin
			case (reg_addr)
				ea_pkg::OFF_MODE:    reg_rdata <= 16'($unsigned(ctrl));
				ea_pkg::OFF_SEL:     reg_rdata <= {8'h00, sel};
				ea_pkg::OFF_EXT0:    reg_rdata <= ext0;
				ea_pkg::OFF_EXT1:    reg_rdata <= ext1;
				ea_pkg::OFF_EA_LO:   reg_rdata <= effective_address[15:0];
				ea_pkg::OFF_EA_HI:   reg_rdata <= {8'h00, effective_address[ADDR_W-1:16]};
				ea_pkg::OFF_STATUS:  reg_rdata <= {14'h0000, state};
				ea_pkg::OFF_SW:      reg_rdata <= status_word;
				ea_pkg::OFF_PC_LO:   reg_rdata <= pc[15:0];
				ea_pkg::OFF_PC_HI:   reg_rdata <= pc[31:16];
				ea_pkg::OFF_OPND_LO: reg_rdata <= operand[15:0];
				ea_pkg::OFF_OPND_HI: reg_rdata <= operand[31:16];
				default:             reg_rdata <= '0;
			endcase
		end else
			reg_rdata <= '0;
	end

	// Checks
	sequence s_start_nobus;
		go && !next_needs_bus;
	endsequence

	property p_direct_no_bus;
		@(posedge sys_clk) disable iff (rst)
		s_start_nobus |=> !bus_out.req ##1 done;
	endproperty
	a_direct_no_bus: assert property (p_direct_no_bus) else $error("direct mode used bus");

	property p_data_direct;
		@(posedge sys_clk) disable iff (rst)
		go && !base_is_addr && ctrl.mode == ea_pkg::M_DATA_DIRECT |=> operand == $past(base_val);
	endproperty
	a_data_direct: assert property (p_data_direct) else $error("data direct operand wrong");

	property p_indirect;
		@(posedge sys_clk) disable iff (rst)
		go && ctrl.mode == ea_pkg::M_INDIRECT |=> bus_out.addr == ADDR_W'($past(base_val));
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect address wrong");

	property p_postinc;
		@(posedge sys_clk) disable iff (rst)
		go && ctrl.mode == ea_pkg::M_POSTINC |=>
			effective_address == $past(base_val) && base_val == $past(base_val) + $past(step);
	endproperty
	a_postinc: assert property (p_postinc) else $error("postincrement wrong");

	property p_predec;
		@(posedge sys_clk) disable iff (rst)
		go && ctrl.mode == ea_pkg::M_PREDEC |=>
			effective_address == base_val && base_val == $past(base_val) - $past(step);
	endproperty
	a_predec: assert property (p_predec) else $error("predecrement wrong");

	property p_stack_byte;
		@(posedge sys_clk) disable iff (rst)
		ctrl.size == ea_pkg::SZ_BYTE && sel.base == ea_pkg::SEL_STACK |-> step == 3'h2;
	endproperty
	a_stack_byte: assert property (p_stack_byte) else $error("stack byte step not 2");

	property p_once;
		@(posedge sys_clk) disable iff (rst)
		state == S_BUS && $past(state) == S_BUS |-> $stable(base_val);
	endproperty
	a_once: assert property (p_once) else $error("write-back repeated in access");

	property p_hold_until_ack;
		@(posedge sys_clk) disable iff (rst)
		bus_out.req && !ack_s2 |=> bus_out.req && $stable(bus_out.addr);
	endproperty
	a_hold_until_ack: assert property (p_hold_until_ack) else $error("request dropped early");

endmodule

//--- verification/mem_responder.sv
// Memory and peripheral responder on the system bus side
`timescale 1ns/1ps

module mem_responder (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire ea_pkg::bus_req_t bus_out,
	input  wire logic [3:0]       wait_cycles,
	output logic                  bus_ack,
	output int                    n_access,
	output logic [23:0]           last_addr,
	output logic                  last_write
);
	logic [3:0] waited;

	// Ack after a chosen wait, held until the request drops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_ack <= 1'b0;
			waited <= 4'h0;
			n_access <= 0;
			last_addr <= 24'h000000;
			last_write <= 1'b0;
		end else if (!bus_out.req) begin
			bus_ack <= 1'b0;
			waited <= 4'h0;
		end else if (!bus_ack) begin
			if (waited >= wait_cycles) begin
				bus_ack <= 1'b1;
				n_access <= n_access + 1;
				last_addr <= bus_out.addr;
				last_write <= bus_out.write;
			end else begin
				waited <= waited + 4'h1;
			end
		end
	end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the effective-address generator
`timescale 1ns/1ps

module tb_top;
	logic                      sys_clk;
	logic                      rst;
	logic                      reg_wr;
	logic                      reg_rd;
	logic [ea_pkg::OFF_W-1:0]  reg_addr;
	logic [ea_pkg::DATA_W-1:0] reg_wdata;
	logic [ea_pkg::DATA_W-1:0] reg_rdata;
	ea_pkg::bus_req_t          bus_out;
	logic                      bus_ack;
	logic                      done;
	logic                      last_write;
	logic [31:0]               operand;
	logic [23:0]               last_addr;
	logic [3:0]                wait_cycles;
	logic [31:0]               r [16];
	int                        n_mismatch;
	int                        n_tests;
	int                        n_access;

	effective_address_generator uut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_out(bus_out),
		.bus_ack(bus_ack), .operand(operand), .done(done)
	);

	mem_responder mem (
		.sys_clk(sys_clk), .rst(rst), .bus_out(bus_out), .wait_cycles(wait_cycles),
		.bus_ack(bus_ack), .n_access(n_access), .last_addr(last_addr),
		.last_write(last_write)
	);

	always #20 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Strobe then an idle edge, so no strobe is driven twice in one step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe; take them mid-cycle
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask

	task automatic ld(input logic [3:0] s, input logic [31:0] v);
		wr(ea_pkg::OFF_WR_LO, v[15:0]);
		wr(ea_pkg::OFF_WR_HI, v[31:16]);
		wr(ea_pkg::OFF_WR_SEL, {12'h000, s});
	endtask

	function automatic logic [11:0] cw(ea_pkg::mode_t m, ea_pkg::size_t_t s, logic [5:0] f);
		return ea_pkg::ctrl_t'({m, s, f});
	endfunction

	function automatic logic [31:0] rv(logic [3:0] s);
		return 32'hA510_0000 + {16'h0000, s, 4'h0, s, 4'h0};
	endfunction

	task automatic go(input logic wf, output logic [31:0] res);
		reg_addr <= ea_pkg::OFF_GO;
		reg_wdata <= {15'h0000, wf};
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		for (int i = 0; i < 64; i++) begin
			@(posedge sys_clk);
			#1;
			if (done === 1'b1) break;
		end
		chk(32'(done), 32'h1);
		res = operand;
		@(posedge sys_clk);
	endtask

	// One access: operand, bus access count, and address and direction on the bus
	task automatic acc(ea_pkg::mode_t m, ea_pkg::size_t_t sz, logic [3:0] b, logic [3:0] x,
			logic [15:0] e0, logic [15:0] e1, logic [5:0] f, logic wf,
			logic [31:0] exp, int nb);
		int n0;
		logic [31:0] res;
		n0 = n_access;
		wr(ea_pkg::OFF_MODE, {4'h0, cw(m, sz, f)});
		wr(ea_pkg::OFF_SEL, {8'h00, b, x});
		wr(ea_pkg::OFF_EXT0, e0);
		wr(ea_pkg::OFF_EXT1, e1);
		go(wf, res);
		chk(res, exp);
		chk(32'(n_access - n0), 32'(nb));
		if (nb != 0) begin
			chk({8'h00, last_addr}, {8'h00, exp[23:0]});
			chk(32'(last_write), 32'(wf));
		end
	endtask

	task automatic stp(ea_pkg::mode_t m, ea_pkg::size_t_t sz, logic [3:0] b, logic [31:0] n);
		logic [31:0] ea;
		if (m == ea_pkg::M_PREDEC) r[b] = r[b] - n;
		ea = r[b];
		if (m == ea_pkg::M_POSTINC) r[b] = r[b] + n;
		acc(m, sz, b, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0, ea, 1);
		acc(ea_pkg::M_ADDR_DIRECT, ea_pkg::SZ_LONG, b, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0,
			r[b], 0);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		logic [15:0] v;
		sys_clk = 1'b0;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		wait_cycles = 4'h0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ea_pkg::OFF_SW, v);
		chk(32'(v), 32'h0000_2700);
		rd(ea_pkg::OFF_PC_LO, v);
		chk(32'(v), 32'h0000_0000);
		rd(ea_pkg::OFF_PC_HI, v);
		chk(32'(v), 32'h0000_0000);
		rd(ea_pkg::OFF_STATUS, v);
		chk(32'(v), 32'h0000_0000);
		wr(ea_pkg::OFF_SW, 16'hFFFF);
		rd(ea_pkg::OFF_SW, v);
		chk(32'(v), 32'h0000_A71F);
		wr(ea_pkg::OFF_SW, 16'h2700);
		$display("test reset done");
		wr(ea_pkg::OFF_MODE, {4'h0, cw(ea_pkg::M_DATA_DIRECT, ea_pkg::SZ_LONG, 6'h00)});
		for (int s = 0; s < 16; s++) begin
			r[s] = rv(4'(s));
			ld(4'(s), r[s]);
		end
		wr(ea_pkg::OFF_MODE, {4'h0, cw(ea_pkg::M_DATA_DIRECT, ea_pkg::SZ_BYTE, 6'h00)});
		ld(4'h0, 32'h1234_56CD);
		r[0][7:0] = 8'hCD;
		wr(ea_pkg::OFF_MODE, {4'h0, cw(ea_pkg::M_DATA_DIRECT, ea_pkg::SZ_WORD, 6'h00)});
		ld(4'h1, 32'h1234_56CD);
		r[1][15:0] = 16'h56CD;
		// Direct modes must not touch the bus
		for (int s = 0; s < 16; s++) begin
			acc(ea_pkg::mode_t'(s < 8 ? ea_pkg::M_DATA_DIRECT : ea_pkg::M_ADDR_DIRECT),
				ea_pkg::SZ_LONG, 4'(s), 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0,
				r[s], 0);
		end
		$display("test direct done");
		acc(ea_pkg::M_ABS_SHORT, ea_pkg::SZ_WORD, 4'h0, 4'h0, 16'h1234, 16'h0000, 6'h00, 1'b1, 32'h0000_1234, 1);
		wait_cycles <= 4'h6;
		acc(ea_pkg::M_ABS_LONG, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h3456, 16'h0012, 6'h00, 1'b0,
			32'h0012_3456, 1);
		acc(ea_pkg::M_PC_DISP, ea_pkg::SZ_WORD, 4'h0, 4'h0, 16'hFFF0, 16'h0000, 6'h00, 1'b1, 32'hFFFF_FFF0, 1);
		wait_cycles <= 4'h0;
		acc(ea_pkg::M_PC_INDEX, ea_pkg::SZ_WORD, 4'h0, 4'h3, 16'h0080, 16'h0000, 6'h01, 1'b0, r[3] + 32'hFFFF_FF80, 1);
		acc(ea_pkg::M_INDIRECT, ea_pkg::SZ_LONG, 4'h9, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0, r[9], 1);
		acc(ea_pkg::M_ADDR_DIRECT, ea_pkg::SZ_LONG, 4'h9, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0, r[9], 0);
		acc(ea_pkg::M_DISP, ea_pkg::SZ_WORD, 4'hA, 4'h0, 16'h8000, 16'h0000, 6'h00, 1'b0, r[10] - 32'h0000_8000, 1);
		acc(ea_pkg::M_INDEX, ea_pkg::SZ_WORD, 4'hB, 4'hC, 16'h007F, 16'h0000, 6'h00, 1'b0, r[11] + 32'hFFFF_C0C0 + 32'h0000_007F, 1);
		$display("test bus modes done");
		stp(ea_pkg::M_POSTINC, ea_pkg::SZ_BYTE, 4'h8, 32'h1);
		stp(ea_pkg::M_POSTINC, ea_pkg::SZ_WORD, 4'hD, 32'h2);
		wait_cycles <= 4'h9;
		stp(ea_pkg::M_PREDEC, ea_pkg::SZ_LONG, 4'hE, 32'h4);
		stp(ea_pkg::M_PREDEC, ea_pkg::SZ_BYTE, 4'hF, 32'h2);
		wait_cycles <= 4'h0;
		stp(ea_pkg::M_POSTINC, ea_pkg::SZ_BYTE, 4'hF, 32'h2);
		$display("test step sizes done");
		acc(ea_pkg::M_IMMEDIATE, ea_pkg::SZ_WORD, 4'h0, 4'h0, 16'h1234, 16'h0000, 6'h00, 1'b0, 32'h0000_1234, 0);
		acc(ea_pkg::M_IMMEDIATE, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'hCDEF, 16'h89AB, 6'h00, 1'b0,
			32'h89AB_CDEF, 0);
		acc(ea_pkg::M_QUICK, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h06, 1'b0, 32'h0000_0003, 0);
		acc(ea_pkg::M_QUICK, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0, 32'h0000_0008, 0);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_WORD, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h00, 1'b0, 32'h0000_2700, 0);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h20, 1'b0, r[15], 0);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h30, 1'b0, 32'h0000_0000, 0);
		// User state: the stack select and the active pointer follow the user stack
		wr(ea_pkg::OFF_SW, 16'h0000);
		ld(4'hF, 32'h0000_1000);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h10, 1'b0,
			32'h0000_1000, 0);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h20, 1'b0,
			32'h0000_1000, 0);
		wr(ea_pkg::OFF_SW, 16'h2700);
		acc(ea_pkg::M_IMPLIED, ea_pkg::SZ_LONG, 4'h0, 4'h0, 16'h0000, 16'h0000, 6'h20, 1'b0,
			r[15], 0);
		$display("test immediate and implied done");
		end_sim();
	end
endmodule
